//--- core/crf_pkg.sv
package crf_pkg;
	// -----------------------------------------------
	// register map on the apb side
	// -----------------------------------------------
	localparam logic [7:0] REG_ACC = 8'h00;
	localparam logic [7:0] REG_IDX = 8'h04;
	localparam logic [7:0] REG_STK = 8'h08;
	localparam logic [7:0] REG_PRG = 8'h0c;
	localparam logic [7:0] REG_FLG = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;

	// -----------------------------------------------
	// reset values and fixed fields
	// -----------------------------------------------
	localparam logic [15:0] STK_RESET = 16'h00ff;
	localparam logic [15:0] PRG_RESET = 16'h0000;
	localparam logic [9:0] STK_HI = 10'b0000000011;
	localparam int STK_W = 6;
	localparam logic [15:0] MEM_MASK = 16'h1fff;
	localparam logic [2:0] FLG_ONES = 3'b111;
	localparam logic [2:0] CALL_BYTES = 3'h2;
	localparam logic [2:0] INT_BYTES = 3'h5;

	// flag positions inside the flag byte
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_I = 3;
	localparam int FL_H = 4;

	// stack item order: push order, pulls run backwards
	localparam logic [2:0] ITEM_PRGL = 3'h0;
	localparam logic [2:0] ITEM_PRGH = 3'h1;
	localparam logic [2:0] ITEM_IDX = 3'h2;
	localparam logic [2:0] ITEM_ACC = 3'h3;

	// -----------------------------------------------
	// operations and states
	// -----------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_FETCH = 5'h01, OP_JUMP = 5'h02,
		OP_LOAD_ACC = 5'h03, OP_LOAD_IDX = 5'h04, OP_ADD = 5'h05,
		OP_ADD_CARRY = 5'h06, OP_INCREMENT = 5'h07, OP_DECREMENT = 5'h08,
		OP_ROTATE_RIGHT = 5'h09, OP_BIT_TEST = 5'h0a, OP_UNSIGNED_MULTIPLY = 5'h0b,
		OP_STACK_POINTER_RELOAD = 5'h0c, OP_MASK_CLEAR = 5'h0d, OP_MASK_SET = 5'h0e,
		OP_HALT = 5'h0f, OP_CALL = 5'h10, OP_SUB_RETURN = 5'h11,
		OP_INTERRUPT = 5'h12, OP_INTERRUPT_RETURN = 5'h13, OP_EA_NO_OFFSET = 5'h14,
		OP_EA_SHORT = 5'h15, OP_EA_LONG = 5'h16
	} crf_op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH = 3'b001,
		ST_PULL_A = 3'b010,
		ST_PULL_W = 3'b011,
		ST_PULL_D = 3'b100
	} crf_state_t;

	// -----------------------------------------------
	// carriers
	// -----------------------------------------------
	typedef struct packed {
		crf_op_t op;
		logic [7:0] imm8;
		logic [15:0] imm16;
	} crf_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} crf_mem_t;
endpackage : crf_pkg

//--- core/crf_add.sv
`timescale 1ns/1ps
// unsigned adder with carry out and nibble carry
module crf_add #(
	parameter int W = 8
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	output logic [W-1:0] sum,
	output logic cout,
	output logic hcarry
);
	logic [W:0] full;
	logic [4:0] low;

	// full sum and low nibble sum
	assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
	assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	assign sum = full[W-1:0];
	assign cout = full[W];
	assign hcarry = low[4];
endmodule : crf_add

//--- core/crf_regs.sv
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
// How it works
// (RQ1) 8-bit accumulator holds operands and results; reset leaves it alone
// (RQ2) indexed no offset: address is zero high byte, index low byte
// (RQ3) indexed short offset: address is index plus the 8-bit immediate
// (RQ4) indexed long offset: address is index plus the 16-bit immediate
// (RQ5) 8-bit index register doubles as storage; reset leaves it alone
// (RQ6) reset and stack reload operation load stack pointer with top of stack
// (RQ7) stack pointer decrements after each push, increments before each pull
// (RQ8) stack addresses use a fixed upper ten bits plus six pointer bits
// (RQ9) only 64 stack places; overflow wraps silently and overwrites
// (RQ10) subroutine call pushes two bytes, interrupt entry pushes five
// (RQ11) program counter steps by one per fetch unless loaded by a jump
// (RQ12) stack pointer and program counter are 16 bits; high address bits ignored
// (RQ13) condition flags are five bits; byte view shows three upper ones
// (RQ14) reset sets the interrupt mask only; clear, stop or wait clear it
// (RQ15) half carry set by add or add with carry on bit 3 carry
// (RQ16) mask blocks interrupts; entry sets mask after stacking, before vector; the code sets the mask and loads the vector on the same clock edge
// (RQ17) a request seen while masked is latched and served once unmasked
// (RQ18) interrupt return restores every stacked register including the mask
// (RQ19) negative flag follows bit 7 of each result
// (RQ20) zero flag set when a result is zero, cleared otherwise
// (RQ21) carry from bit 7, shifts, bit tests; untouched by increment, decrement
// (RQ22) multiply puts high product byte in index, low byte in accumulator
module crf_regs
	import crf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_valid,
	input wire crf_req_t op_req,
	output logic op_ready,
	input wire logic irq_req,
	output logic irq_take,
	input wire logic [7:0] mem_rdata,
	output crf_mem_t mem_out,
	output logic [15:0] eff_addr
);
	// -----------------------------------------------
	// storage
	// -----------------------------------------------
	logic [7:0] acc_q;
	logic [7:0] idx_q;
	logic flag_h_q;
	logic flag_n_q;
	logic flag_z_q;
	logic flag_c_q;
	logic mask_q;
	logic [15:0] stk_ptr_q;
	logic [15:0] prg_cnt_q;
	logic irq_pend_q;
	logic irq_take_q;
	logic op_ready_q;
	crf_state_t st_q;
	crf_state_t st_d;
	logic [2:0] cnt_q;
	logic [2:0] nbytes_q;
	logic is_int_q;
	logic [15:0] vec_q;
	crf_mem_t mem_q;
	logic [15:0] ea_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// -----------------------------------------------
	// apb decode
	// -----------------------------------------------
	wire sel_acc = (paddr == REG_ACC);
	wire sel_idx = (paddr == REG_IDX);
	wire sel_stk = (paddr == REG_STK);
	wire sel_prg = (paddr == REG_PRG);
	wire sel_flg = (paddr == REG_FLG);
	wire sel_stat = (paddr == REG_STAT);
	wire bad_addr = ~(sel_acc | sel_idx | sel_stk | sel_prg | sel_flg | sel_stat);
	wire apb_first = psel & penable & ~pready_q;
	wire apb_done = psel & penable & pready_q;
	wire apb_wr = apb_done & pwrite & ~bad_addr;

	// byte view of the flags, upper three read as ones
	wire [7:0] flg_byte = {FLG_ONES, flag_h_q, mask_q, flag_n_q, flag_z_q, flag_c_q}; // [RQ13]
	wire [31:0] stat_word = {29'h0000000, irq_take_q, irq_pend_q, ~op_ready_q};

	// read data select
	wire [31:0] rd_word =
		sel_acc ? {24'h000000, acc_q} :
		sel_idx ? {24'h000000, idx_q} :
		sel_stk ? {16'h0000, stk_ptr_q} :
		sel_prg ? {16'h0000, prg_cnt_q} :
		sel_flg ? {24'h000000, flg_byte} :
		sel_stat ? stat_word : 32'h00000000;

	// -----------------------------------------------
	// operation decode
	// -----------------------------------------------
	wire fire = op_valid & op_ready_q;
	wire do_fetch = fire & (op_req.op == OP_FETCH);
	wire do_jump = fire & (op_req.op == OP_JUMP);
	wire do_lda = fire & (op_req.op == OP_LOAD_ACC);
	wire do_ldx = fire & (op_req.op == OP_LOAD_IDX);
	wire do_add = fire & (op_req.op == OP_ADD);
	wire do_adc = fire & (op_req.op == OP_ADD_CARRY);
	wire do_inc = fire & (op_req.op == OP_INCREMENT);
	wire do_dec = fire & (op_req.op == OP_DECREMENT);
	wire do_ror = fire & (op_req.op == OP_ROTATE_RIGHT);
	wire do_btst = fire & (op_req.op == OP_BIT_TEST);
	wire do_mul = fire & (op_req.op == OP_UNSIGNED_MULTIPLY);
	wire do_reload = fire & (op_req.op == OP_STACK_POINTER_RELOAD);
	wire do_mclr = fire & ((op_req.op == OP_MASK_CLEAR) | (op_req.op == OP_HALT));
	wire do_mset = fire & (op_req.op == OP_MASK_SET);
	wire do_call = fire & (op_req.op == OP_CALL);
	wire do_rts = fire & (op_req.op == OP_SUB_RETURN);
	wire do_int = fire & (op_req.op == OP_INTERRUPT) & ~mask_q; // [RQ16]
	wire do_rti = fire & (op_req.op == OP_INTERRUPT_RETURN);
	wire do_ea0 = fire & (op_req.op == OP_EA_NO_OFFSET);
	wire do_ea1 = fire & (op_req.op == OP_EA_SHORT);
	wire do_ea2 = fire & (op_req.op == OP_EA_LONG);

	// -----------------------------------------------
	// arithmetic
	// -----------------------------------------------
	logic [7:0] alu_sum;
	logic alu_c;
	logic alu_h;
	logic [15:0] ea_sum;

	// accumulator adder, carry in only for add with carry
	crf_add #(
		.W(8)
	) u_alu (
		.a(acc_q),
		.b(op_req.imm8),
		.cin(do_adc & flag_c_q),
		.sum(alu_sum),
		.cout(alu_c),
		.hcarry(alu_h)
	);

	// effective address adder, index is unsigned
	wire [15:0] ea_off = do_ea2 ? op_req.imm16 : {8'h00, op_req.imm8}; // [RQ3] [RQ4]
	crf_add #(
		.W(16)
	) u_ea (
		.a({8'h00, idx_q}),
		.b(ea_off),
		.cin(1'b0),
		.sum(ea_sum),
		.cout(),
		.hcarry()
	);
	wire [15:0] ea_next = do_ea0 ? {8'h00, idx_q} : ea_sum; // [RQ2]

	// result of the single step data operations
	wire [7:0] res =
		(do_lda | do_ldx) ? op_req.imm8 :
		(do_add | do_adc) ? alu_sum :
		do_inc ? acc_q + 8'h01 :
		do_dec ? acc_q - 8'h01 :
		{flag_c_q, acc_q[7:1]};
	wire acc_upd = do_lda | do_add | do_adc | do_inc | do_dec | do_ror;
	wire nz_upd = acc_upd | do_ldx;
	wire [15:0] prod = {8'h00, acc_q} * {8'h00, idx_q};
	wire test_bit = op_req.imm8[op_req.imm16[2:0]];

	// -----------------------------------------------
	// stack sequencing
	// -----------------------------------------------
	wire [STK_W-1:0] stk_lo = stk_ptr_q[STK_W-1:0];
	wire [STK_W-1:0] stk_lo_dec = stk_lo - 6'h01;
	wire [STK_W-1:0] stk_lo_inc = stk_lo + 6'h01;
	wire last = (cnt_q == nbytes_q - 3'h1);
	wire [2:0] item = (st_q == ST_PUSH) ? cnt_q : nbytes_q - 3'h1 - cnt_q;
	wire pull_cap = (st_q == ST_PULL_D);
	wire push_end = (st_q == ST_PUSH) & last;
	wire [7:0] push_byte =
		(item == ITEM_PRGL) ? prg_cnt_q[7:0] :
		(item == ITEM_PRGH) ? prg_cnt_q[15:8] :
		(item == ITEM_IDX) ? idx_q :
		(item == ITEM_ACC) ? acc_q : flg_byte;

	// next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (do_call | do_int)
					st_d = ST_PUSH;
				else if (do_rts | do_rti)
					st_d = ST_PULL_A;
			end
			ST_PUSH: begin
				if (last)
					st_d = ST_IDLE;
			end
			ST_PULL_A: st_d = ST_PULL_W;
			ST_PULL_W: st_d = ST_PULL_D;
			ST_PULL_D: st_d = last ? ST_IDLE : ST_PULL_A;
			default: st_d = ST_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			cnt_q <= 3'h0;
			nbytes_q <= CALL_BYTES;
			is_int_q <= 1'b0;
			vec_q <= PRG_RESET;
			op_ready_q <= 1'b1;
		end else begin
			st_q <= st_d;
			op_ready_q <= (st_d == ST_IDLE);
			if (st_q == ST_IDLE) begin
				cnt_q <= 3'h0;
				nbytes_q <= (do_int | do_rti) ? INT_BYTES : CALL_BYTES; // [RQ10]
				is_int_q <= do_int;
				vec_q <= op_req.imm16;
			end else if ((st_q == ST_PUSH) | pull_cap) begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	// memory port: stack writes and reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_q <= '0;
		end else begin
			mem_q.we <= (st_q == ST_PUSH);
			mem_q.re <= (st_q == ST_PULL_A);
			if (st_q == ST_PUSH) begin
				mem_q.addr <= {STK_HI, stk_lo} & MEM_MASK; // [RQ8] [RQ12]
				mem_q.wdata <= push_byte;
			end else if (st_q == ST_PULL_A) begin
				mem_q.addr <= {STK_HI, stk_lo_inc} & MEM_MASK; // [RQ8]
			end
		end
	end

	// -----------------------------------------------
	// stack pointer, program counter, mask
	// -----------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stk_ptr_q <= STK_RESET; // [RQ6]
		end else begin
			if (apb_wr & sel_stk)
				stk_ptr_q <= pwdata[15:0];
			if (do_reload)
				stk_ptr_q <= STK_RESET; // [RQ6]
			if (st_q == ST_PUSH)
				stk_ptr_q[STK_W-1:0] <= stk_lo_dec; // [RQ7] [RQ9]
			if (st_q == ST_PULL_A)
				stk_ptr_q[STK_W-1:0] <= stk_lo_inc; // [RQ7]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prg_cnt_q <= PRG_RESET;
		end else begin
			if (apb_wr & sel_prg)
				prg_cnt_q <= pwdata[15:0]; // [RQ12]
			if (do_fetch)
				prg_cnt_q <= prg_cnt_q + 16'h0001; // [RQ11]
			if (do_jump | (push_end & ~is_int_q))
				prg_cnt_q <= do_jump ? op_req.imm16 : vec_q; // [RQ11]
			if (push_end & is_int_q)
				prg_cnt_q <= vec_q;
			if (pull_cap & (item == ITEM_PRGL))
				prg_cnt_q[7:0] <= mem_rdata;
			if (pull_cap & (item == ITEM_PRGH))
				prg_cnt_q[15:8] <= mem_rdata;
		end
	end

	// mask: set by reset, restored by interrupt return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 1'b1; // [RQ14]
		end else begin
			if (apb_wr & sel_flg)
				mask_q <= pwdata[FL_I];
			if (do_mclr)
				mask_q <= 1'b0; // [RQ14]
			if (do_mset | (push_end & is_int_q))
				mask_q <= 1'b1; // [RQ16]
			if (pull_cap & (item > ITEM_ACC))
				mask_q <= mem_rdata[FL_I]; // [RQ18]
		end
	end

	// pending latch: a new request beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pend_q <= 1'b0;
			irq_take_q <= 1'b0;
		end else begin
			irq_pend_q <= irq_req | (irq_pend_q & ~do_int); // [RQ17]
			irq_take_q <= irq_pend_q & ~mask_q & ~do_int; // [RQ16] [RQ17]
		end
	end

	// effective address output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ea_q <= 16'h0000;
		else if (do_ea0 | do_ea1 | do_ea2)
			ea_q <= ea_next & MEM_MASK; // [RQ2] [RQ3] [RQ4]
	end

	// -----------------------------------------------
	// data registers, untouched by reset
	// -----------------------------------------------
	always_ff @(posedge pclk) begin
		if (apb_wr & sel_acc)
			acc_q <= pwdata[7:0];
		if (apb_wr & sel_idx)
			idx_q <= pwdata[7:0];
		if (acc_upd)
			acc_q <= res; // [RQ1]
		if (do_ldx)
			idx_q <= res; // [RQ5]
		if (do_mul)
			{idx_q, acc_q} <= prod; // [RQ22]
		if (pull_cap & (item == ITEM_ACC))
			acc_q <= mem_rdata; // [RQ18]
		if (pull_cap & (item == ITEM_IDX))
			idx_q <= mem_rdata; // [RQ18]
	end

	// result flags
	always_ff @(posedge pclk) begin
		if (apb_wr & sel_flg)
			{flag_h_q, flag_n_q, flag_z_q, flag_c_q} <= {pwdata[FL_H], pwdata[FL_N], pwdata[FL_Z], pwdata[FL_C]};
		if (nz_upd) begin
			flag_n_q <= res[7]; // [RQ19]
			flag_z_q <= (res == 8'h00); // [RQ20]
		end
		if (do_add | do_adc) begin
			flag_h_q <= alu_h; // [RQ15]
			flag_c_q <= alu_c; // [RQ21]
		end
		if (do_ror)
			flag_c_q <= acc_q[0]; // [RQ21]
		if (do_btst)
			flag_c_q <= test_bit; // [RQ21]
		if (do_mul) begin
			flag_h_q <= 1'b0;
			flag_c_q <= 1'b0;
		end
		if (pull_cap & (item > ITEM_ACC))
			{flag_h_q, flag_n_q, flag_z_q, flag_c_q} <=
				{mem_rdata[FL_H], mem_rdata[FL_N], mem_rdata[FL_Z], mem_rdata[FL_C]}; // [RQ18]
	end

	// -----------------------------------------------
	// apb slave, one wait state
	// -----------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_first;
			pslverr_q <= apb_first & bad_addr;
			if (apb_first)
				prdata_q <= rd_word;
		end
	end

	// outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign op_ready = op_ready_q;
	assign irq_take = irq_take_q;
	assign mem_out = mem_q;
	assign eff_addr = ea_q;

	// -----------------------------------------------
	// checks
	// -----------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_push2;
		!mem_q.we ##1 mem_q.we [*2] ##1 !mem_q.we;
	endsequence
	sequence s_push5;
		!mem_q.we ##1 mem_q.we [*5] ##1 !mem_q.we;
	endsequence

	property p_call_two;
		do_call |=> s_push2;
	endproperty
	a_call_two : assert property (p_call_two) else $error("call did not push two bytes"); // [RQ10]

	property p_int_five;
		do_int |=> s_push5;
	endproperty
	a_int_five : assert property (p_int_five) else $error("interrupt did not push five bytes"); // [RQ10]

	property p_int_mask;
		do_int |-> ##1 !mask_q [*5] ##1 mask_q;
	endproperty
	a_int_mask : assert property (p_int_mask) else $error("mask not set after stacking"); // [RQ16]

	property p_stk_addr;
		mem_q.we |-> mem_q.addr[15:STK_W] == STK_HI;
	endproperty
	a_stk_addr : assert property (p_stk_addr) else $error("stack address upper bits wrong"); // [RQ8]

	property p_push_dec;
		(st_q == ST_PUSH) |=> stk_ptr_q[STK_W-1:0] == $past(stk_lo) - 6'h01;
	endproperty
	a_push_dec : assert property (p_push_dec) else $error("stack pointer not decremented"); // [RQ7] [RQ9]

	property p_reload;
		do_reload & (st_q == ST_IDLE) |=> stk_ptr_q == STK_RESET;
	endproperty
	a_reload : assert property (p_reload) else $error("stack pointer not reloaded"); // [RQ6]

	property p_fetch;
		do_fetch |=> prg_cnt_q == $past(prg_cnt_q) + 16'h0001;
	endproperty
	a_fetch : assert property (p_fetch) else $error("program counter did not step"); // [RQ11]

	property p_half;
		do_add |=> flag_h_q == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(op_req.imm8[3:0])}) > 5'h0f);
	endproperty
	a_half : assert property (p_half) else $error("half carry wrong"); // [RQ15]

	property p_mul;
		do_mul |=> {idx_q, acc_q} == {8'h00, $past(acc_q)} * {8'h00, $past(idx_q)};
	endproperty
	a_mul : assert property (p_mul) else $error("product placed wrongly"); // [RQ22]

	property p_incdec_c;
		do_inc | do_dec |=> flag_c_q == $past(flag_c_q);
	endproperty
	a_incdec_c : assert property (p_incdec_c) else $error("carry changed on step"); // [RQ21]

	property p_load_nz;
		do_lda |=> (flag_n_q == acc_q[7]) && (flag_z_q == (acc_q == 8'h00));
	endproperty
	a_load_nz : assert property (p_load_nz) else $error("load flags wrong"); // [RQ19] [RQ20]

	property p_ea0;
		do_ea0 |=> ea_q == {8'h00, $past(idx_q)};
	endproperty
	a_ea0 : assert property (p_ea0) else $error("no offset address wrong"); // [RQ2]

	property p_take;
		irq_take_q |-> $past(irq_pend_q) && !$past(mask_q);
	endproperty
	a_take : assert property (p_take) else $error("interrupt offered while masked"); // [RQ17]
endmodule : crf_regs

//--- dv/crf_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// stack memory on the internal bus
// ----------------------------------------
module crf_mem_model
	import crf_pkg::*;
(
	input wire logic pclk,
	input wire crf_mem_t mem_out,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem_q [256];

	initial mem_rdata = 8'h00;

	// store on write strobe; data valid the cycle after a read strobe, churning otherwise
	always @(posedge pclk) begin
		if (mem_out.we)
			mem_q[mem_out.addr[7:0]] <= mem_out.wdata;
		mem_rdata <= mem_out.re ? mem_q[mem_out.addr[7:0]] : ~mem_rdata;
	end
endmodule : crf_mem_model

//--- dv/crf_regs_bench.sv
`timescale 1ns/1ps
module crf_regs_bench
	import crf_pkg::*;
;
	typedef struct {
		logic [31:0] v;
		logic [31:0] m;
		logic e;
	} crf_exp_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_valid, op_ready, irq_req, irq_take;
	logic [7:0] paddr, mem_rdata, a, x, t, a0;
	logic [31:0] pwdata, prdata, f0;
	logic [15:0] eff_addr, p, q, pr;
	logic [8:0] s;
	logic [4:0] lo;
	logic hf, im, nf, zf, cf;
	crf_req_t op_req;
	crf_mem_t mem_out;
	crf_exp_t rd_q[$], wr_q[$], e;
	int mismatches, n_compared;

	crf_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.op_valid(op_valid), .op_req(op_req), .op_ready(op_ready), .irq_req(irq_req),
		.irq_take(irq_take), .mem_rdata(mem_rdata), .mem_out(mem_out), .eff_addr(eff_addr));
	crf_mem_model mem_u (.pclk(pclk), .mem_out(mem_out), .mem_rdata(mem_rdata));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		n_compared++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
		end
	endtask : chk

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst

	// apb transfer, expectation noted for the monitor
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic [31:0] v, input logic [31:0] m, input logic er);
		rd_q.push_back('{v, m, er});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		repeat (20) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic op(input crf_op_t o, input logic [7:0] i8, input logic [15:0] i16);
		@(posedge pclk);
		op_valid <= 1'b1;
		op_req <= {o, i8, i16};
		repeat (20) begin
			@(posedge pclk);
			if (op_ready === 1'b1)
				break;
		end
		op_valid <= 1'b0;
		repeat (40) begin
			@(posedge pclk);
			if (op_ready === 1'b1)
				break;
		end
	endtask : op

	function automatic logic [31:0] fl();
		return {24'h0, 3'b111, hf, im, nf, zf, cf};
	endfunction : fl

	task automatic nz();
		nf = a[7];
		zf = (a == 8'h00);
	endtask : nz

	task automatic rda();
		bus(1'b0, REG_ACC, 32'h0, {24'h0, a}, 32'hff, 1'b0);
	endtask : rda

	task automatic rdf();
		bus(1'b0, REG_FLG, 32'h0, fl(), 32'hff, 1'b0);
	endtask : rdf

	task automatic rdw(input logic [7:0] ad, input logic [15:0] v, input logic [15:0] m);
		bus(1'b0, ad, 32'h0, {16'h0, v}, {16'h0, m}, 1'b0);
	endtask : rdw

	task automatic wpush(input logic [15:0] ad, input logic [7:0] d, input logic [7:0] m);
		wr_q.push_back('{{8'h0, ad, d}, {16'hff, 8'hff, m}, 1'b0});
	endtask : wpush

	task automatic add(input logic cy, input logic [7:0] b);
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy & cf};
		s = {1'b0, a} + {1'b0, b} + {8'h0, cy & cf};
		op(cy ? OP_ADD_CARRY : OP_ADD, b, 16'h0);
		a = s[7:0];
		hf = lo[4];
		cf = s[8];
		nz();
	endtask : add

	// ----------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// oldest note taken off per apb completion or stack write
	always @(negedge pclk) begin
		if (psel && penable && pready) begin
			e = rd_q.pop_front();
			chk(prdata, e.v, e.m);
			chk({31'h0, pslverr}, {31'h0, e.e}, 32'h1);
		end
		if (mem_out.we === 1'b1) begin
			e = wr_q.pop_front();
			chk({8'h0, mem_out.addr, mem_out.wdata}, e.v, e.m);
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		conclude();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		op_valid = 1'b0;
		op_req = '0;
		irq_req = 1'b0;
		mismatches = 0;
		n_compared = 0;
		im = 1'b1;
		void'($urandom(18530));
		rst();
		rdw(REG_STK, STK_RESET, 16'hffff);
		rdw(REG_PRG, PRG_RESET, 16'hffff);
		bus(1'b1, 8'h40, 32'h5, 32'h0, 32'h0, 1'b1);
		bus(1'b0, 8'h44, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		// random loads and sums
		t = 8'($urandom);
		op(OP_LOAD_ACC, t, 16'h0);
		a = t;
		nz();
		for (int j = 0; j < 8; j++) begin
			add(j[0], 8'($urandom));
			rda();
			rdf();
		end
		// mid-run reset keeps data, sets mask, reloads stack pointer
		x = 8'($urandom);
		bus(1'b1, REG_IDX, {24'h0, x}, 32'h0, 32'h0, 1'b0);
		bus(1'b1, REG_STK, 32'h0011, 32'h0, 32'h0, 1'b0);
		rst();
		rda();
		rdw(REG_IDX, {8'h0, x}, 16'h00ff);
		rdf();
		rdw(REG_STK, STK_RESET, 16'hffff);
		// multiply
		pr = a * x;
		op(OP_UNSIGNED_MULTIPLY, 8'h0, 16'h0);
		a = pr[7:0];
		x = pr[15:8];
		hf = 1'b0;
		cf = 1'b0;
		rda();
		rdw(REG_IDX, {8'h0, x}, 16'h00ff);
		// indexed effective addresses
		t = 8'($urandom);
		p = 16'($urandom);
		op(OP_EA_NO_OFFSET, t, p);
		chk({16'h0, eff_addr}, {24'h0, x}, 32'hffff);
		op(OP_EA_SHORT, t, p);
		chk({16'h0, eff_addr}, {16'h0, ({8'h0, x} + {8'h0, t}) & MEM_MASK}, 32'hffff);
		op(OP_EA_LONG, t, p);
		chk({16'h0, eff_addr}, {16'h0, ({8'h0, x} + p) & MEM_MASK}, 32'hffff);
		// carry from bit test survives increment and decrement
		for (int j = 0; j < 2; j++) begin
			op(OP_BIT_TEST, j[0] ? 8'h10 : 8'hef, 16'h4);
			cf = j[0];
			op(OP_INCREMENT, 8'h0, 16'h0);
			a = a + 8'h1;
			nz();
			rdf();
			op(OP_DECREMENT, 8'h0, 16'h0);
			a = a - 8'h1;
			nz();
			rdf();
		end
		// rotate through carry, then load index
		t = a;
		op(OP_ROTATE_RIGHT, 8'h0, 16'h0);
		a = {cf, t[7:1]};
		cf = t[0];
		nz();
		rda();
		rdf();
		t = 8'($urandom);
		op(OP_LOAD_IDX, t, 16'h0);
		x = t;
		nf = t[7];
		zf = (t == 8'h00);
		rdw(REG_IDX, {8'h0, x}, 16'h00ff);
		rdf();
		// jump then fetch
		p = 16'($urandom & 32'h0ffe);
		op(OP_JUMP, 8'h0, p);
		op(OP_FETCH, 8'h0, 16'h0);
		p = p + 16'h1;
		rdw(REG_PRG, p, 16'hffff);
		// call and return
		bus(1'b1, REG_STK, 32'h0011, 32'h0, 32'h0, 1'b0);
		op(OP_STACK_POINTER_RELOAD, 8'h0, 16'h0);
		rdw(REG_STK, 16'h00ff, 16'hffff);
		q = 16'($urandom & 32'h1fff);
		wpush(16'h00ff, p[7:0], 8'hff);
		wpush(16'h00fe, p[15:8], 8'hff);
		op(OP_CALL, 8'h0, q);
		rdw(REG_PRG, q, 16'hffff);
		rdw(REG_STK, 16'h00fd, 16'hffff);
		op(OP_SUB_RETURN, 8'h0, 16'h0);
		rdw(REG_PRG, p, 16'hffff);
		rdw(REG_STK, 16'h00ff, 16'hffff);
		// stack at its lowest place wraps to the top
		bus(1'b1, REG_STK, 32'h00c0, 32'h0, 32'h0, 1'b0);
		wpush(16'h00c0, p[7:0], 8'hff);
		wpush(16'h00ff, p[15:8], 8'hff);
		op(OP_CALL, 8'h0, q);
		rdw(REG_STK, 16'h003e, 16'h003f);
		p = q;
		// masked request is ignored and latched
		@(posedge pclk);
		irq_req <= 1'b1;
		@(posedge pclk);
		irq_req <= 1'b0;
		op(OP_INTERRUPT, 8'h0, 16'h0345);
		rdw(REG_PRG, p, 16'hffff);
		chk({31'h0, irq_take}, 32'h0, 32'h1);
		op(OP_MASK_CLEAR, 8'h0, 16'h0);
		im = 1'b0;
		repeat (4) begin
			@(negedge pclk);
			if (irq_take === 1'b1)
				break;
		end
		chk({31'h0, irq_take}, 32'h1, 32'h1);
		// interrupt entry and return
		op(OP_STACK_POINTER_RELOAD, 8'h0, 16'h0);
		f0 = fl();
		a0 = a;
		wpush(16'h00ff, p[7:0], 8'hff);
		wpush(16'h00fe, p[15:8], 8'hff);
		wpush(16'h00fd, x, 8'hff);
		wpush(16'h00fc, a, 8'hff);
		wpush(16'h00fb, f0[7:0], 8'h1f);
		op(OP_INTERRUPT, 8'h0, 16'h0345);
		im = 1'b1;
		rdf();
		rdw(REG_PRG, 16'h0345, 16'hffff);
		rdw(REG_STK, 16'h00fa, 16'hffff);
		op(OP_LOAD_ACC, ~a0, 16'h0);
		op(OP_INTERRUPT_RETURN, 8'h0, 16'h0);
		im = 1'b0;
		rdf();
		rda();
		rdw(REG_PRG, p, 16'hffff);
		rdw(REG_STK, 16'h00ff, 16'hffff);
		// mask set, then halt clears it
		op(OP_MASK_SET, 8'h0, 16'h0);
		im = 1'b1;
		rdf();
		op(OP_HALT, 8'h0, 16'h0);
		im = 1'b0;
		rdf();
		repeat (4) @(posedge pclk);
		chk(32'(rd_q.size() + wr_q.size()), 32'h0, 32'hff);
		conclude();
	end
endmodule : crf_regs_bench
